// ### include/brp_pkg.sv
// Shared constants, encodings and types of the bus response-phase agent.
package brp_pkg;

   // Pending transaction queue shape.
   localparam int QUEUE_DEPTH = 8;
   localparam int QPTR_W = 3;
   localparam int STAMP_W = 8;

   // Response code encodings, bit2..bit0, a one is an active bit.
   localparam logic [2:0] RESP_IDLE = 3'h0;
   localparam logic [2:0] RESP_RETRY = 3'h1;
   localparam logic [2:0] RESP_DEFERRED = 3'h2;
   localparam logic [2:0] RESP_RESERVED = 3'h3;
   localparam logic [2:0] RESP_HARD_FAIL = 3'h4;
   localparam logic [2:0] RESP_NO_DATA = 3'h5;
   localparam logic [2:0] RESP_IWB = 3'h6;
   localparam logic [2:0] RESP_NORMAL = 3'h7;

   // Timing counts, in bus clocks.
   localparam int REQ_TO_WDA_CLK = 3;
   localparam int SNOOP_TO_RESP_CLK = 2;
   localparam int RESP_SPACING_CLK = 3;
   localparam int WDA_LOW_MIN_CLK = 3;

   // Derived compare values. A decision is registered one clock before
   // it shows on the bus, hence the minus one in REQ_WDA_AGE.
   localparam logic [7:0] REQ_WDA_AGE = 8'(REQ_TO_WDA_CLK - 1);
   localparam logic [1:0] GAP_MIN = 2'(RESP_SPACING_CLK - 2);
   localparam logic [1:0] WDA_LOW_MIN = 2'(WDA_LOW_MIN_CLK);

   // Reset values of the saturating counters and of the wrapping stamp clock.
   localparam logic [1:0] GAP_RST = 2'h3;
   localparam logic [1:0] WDA_LOW_RST = 2'h3;
   localparam logic [7:0] STAMP_RST = 8'h00;

   // Head transaction handling states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ_WDA,
      ST_REQ_TAKEN,
      ST_REQ_DONE,
      ST_WB_WDA,
      ST_RESP
   } brp_state_t;

   // Any active response bit marks a driven response.
   function automatic logic resp_active(input logic [2:0] code);
      return |code;
   endfunction

endpackage

// ### rtl/brp_txn_queue.sv
// In-order queue of pending bus transactions with snoop results per entry.
module brp_txn_queue (
   // Clock and reset.
   input logic clk_sys_i,
   input logic rst_i,
   // New request.
   input logic push_i,
   input logic push_write_i,
   input logic push_ours_i,
   // Snoop results for the oldest unsnooped entry.
   input logic snoop_i,
   input logic snoop_mod_hit_i,
   input logic snoop_defer_i,
   // Completion of the head entry.
   input logic pop_i,
   // Head entry view.
   output logic head_valid_o,
   output logic head_write_o,
   output logic head_ours_o,
   output logic head_snooped_o,
   output logic head_mod_hit_o,
   output logic head_defer_o,
   output logic [7:0] head_age_o,
   output logic [3:0] count_o
);

   localparam int QPTR_W_L = brp_pkg::QPTR_W;
   logic [QPTR_W_L-1:0] wr_ptr;
   logic [QPTR_W_L-1:0] rd_ptr;
   logic [QPTR_W_L-1:0] sn_ptr;
   logic [7:0] now;
   logic ent_write [brp_pkg::QUEUE_DEPTH];
   logic ent_ours [brp_pkg::QUEUE_DEPTH];
   logic ent_snooped [brp_pkg::QUEUE_DEPTH];
   logic ent_mod_hit [brp_pkg::QUEUE_DEPTH];
   logic ent_defer [brp_pkg::QUEUE_DEPTH];
   logic [7:0] ent_stamp [brp_pkg::QUEUE_DEPTH];

   // Head view. The age wraps after 256 clocks; that can only delay a
   // write accept by a clock or two, never make it early.
   assign head_valid_o = (count_o != 4'h0);
   assign head_write_o = ent_write[rd_ptr];
   assign head_ours_o = ent_ours[rd_ptr];
   assign head_snooped_o = ent_snooped[rd_ptr];
   assign head_mod_hit_o = ent_mod_hit[rd_ptr];
   assign head_defer_o = ent_defer[rd_ptr];
   assign head_age_o = 8'(now - ent_stamp[rd_ptr]);

   // Pointers, occupancy and the free-running stamp clock.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         sn_ptr <= '0;
         count_o <= 4'h0;
         now <= brp_pkg::STAMP_RST;
      end else begin
         now <= 8'(now + 8'h01);
         if (push_i) wr_ptr <= QPTR_W_L'(wr_ptr + 1'b1);
         if (snoop_i) sn_ptr <= QPTR_W_L'(sn_ptr + 1'b1);
         if (pop_i) rd_ptr <= QPTR_W_L'(rd_ptr + 1'b1);
         count_o <= 4'(count_o + {3'h0, push_i} - {3'h0, pop_i});
      end
   end

   // One storage slot per entry; each slot is written only at its index.
   for (genvar i = 0; i < brp_pkg::QUEUE_DEPTH; i++) begin : g_ent
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
         if (rst_i) begin
            ent_write[i] <= 1'b0;
            ent_ours[i] <= 1'b0;
            ent_snooped[i] <= 1'b0;
            ent_mod_hit[i] <= 1'b0;
            ent_defer[i] <= 1'b0;
            ent_stamp[i] <= brp_pkg::STAMP_RST;
         end else if (push_i && wr_ptr == QPTR_W_L'(i)) begin
            ent_write[i] <= push_write_i;
            ent_ours[i] <= push_ours_i;
            ent_snooped[i] <= 1'b0;
            ent_mod_hit[i] <= 1'b0;
            ent_defer[i] <= 1'b0;
            ent_stamp[i] <= now;
         end else if (snoop_i && sn_ptr == QPTR_W_L'(i)) begin
            ent_snooped[i] <= 1'b1;
            ent_mod_hit[i] <= snoop_mod_hit_i;
            ent_defer[i] <= snoop_defer_i;
         end
      end
   end

endmodule

// ### rtl/brp_resp_agent.sv
// Response-phase agent: completes the bus transactions that it owns.
//
// Operation
// - Only the oldest queued transaction may respond.
// - The address-decoded agent alone drives the response.
// - All agents drop a completed transaction.
// - Parity covers the three response code bits.
// - Idle code until driven; any bit marks response.
// - Write accept only with write or writeback data.
// - Read data waits for data bus busy inactive.
// - Previous response and data phase finish first.
// - Response two clocks after snoop; busy postpones.
// - Write accept between previous and own response.
// - Request write accept three clocks after request.
// - One-clock accept needs free bus, long idle.
// - Accept may stay until the response.
// - Write no-data response after accept cycle, snoop.
// - Modified hit gets a writeback accept.
// - Writeback response one clock after accepted.
// - Write plus writeback needs two accepts.
// - Writeback accept drops when taken or responding.
// - Writeback accept follows snoop, after write accept.
// - Writeback accept drops with the writeback response.
// - Response holds one clock, then idle.
// - Responses at least three clocks apart.
// - Pending count drops on each observed response.
// - Dataless responses ignore data bus busy.
module brp_resp_agent (
   // Clock and reset.
   input logic clk_sys_i,
   input logic rst_i,
   // Request phase, as seen on the bus.
   input logic request_strobe_i,
   input logic write_request_flag_i,
   input logic addr_hit_i,
   // Snoop phase results, valid in the clock they are driven.
   input logic snoop_valid_i,
   input logic modified_hit_i,
   input logic snoop_defer_i,
   // Data phase and response lines, as seen on the bus.
   input logic data_bus_busy_i,
   input logic [2:0] response_code_i,
   // Response lines driven by this agent.
   output logic [2:0] response_code_o,
   output logic response_parity_o,
   output logic response_oe_o,
   // Write data accept strobe driven by this agent.
   output logic write_data_accept_o,
   output logic write_data_accept_oe_o,
   // Queue occupancy.
   output logic [3:0] pending_count_o
);

   brp_pkg::brp_state_t state;
   brp_pkg::brp_state_t next_state;
   logic [2:0] next_code;
   logic next_oe;
   logic next_wda;
   logic next_fast_ok;
   logic fast_ok;
   logic [1:0] gap_cnt;
   logic [1:0] wda_low_cnt;
   logic head_valid;
   logic head_write;
   logic head_ours;
   logic head_snooped;
   logic head_mod_hit;
   logic head_defer;
   logic [7:0] head_age;
   logic bus_resp;
   logic own_head;
   logic gap_ok;
   logic age_ok;
   logic low_ok;
   logic read_go;

   ////////////////////////////////////////////////////////////////////////
   // Pending transaction queue, shared view of every agent.

   brp_txn_queue u_queue (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .push_i(request_strobe_i),
      .push_write_i(write_request_flag_i),
      .push_ours_i(addr_hit_i),
      .snoop_i(snoop_valid_i),
      .snoop_mod_hit_i(modified_hit_i),
      .snoop_defer_i(snoop_defer_i),
      .pop_i(bus_resp),
      .head_valid_o(head_valid),
      .head_write_o(head_write),
      .head_ours_o(head_ours),
      .head_snooped_o(head_snooped),
      .head_mod_hit_o(head_mod_hit),
      .head_defer_o(head_defer),
      .head_age_o(head_age),
      .count_o(pending_count_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoding of the bus view.

   // Any agent's response, including our own, completes the head entry.
   assign bus_resp = brp_pkg::resp_active(response_code_i);
   // Only the head entry, and only if our address decode claimed it.
   assign own_head = head_valid & head_ours;
   // The previous response was seen and then sampled idle long enough.
   assign gap_ok = (gap_cnt >= brp_pkg::GAP_MIN);
   assign age_ok = (head_age >= brp_pkg::REQ_WDA_AGE);
   assign low_ok = (wda_low_cnt >= brp_pkg::WDA_LOW_MIN);
   // Read data must not collide with the previous data transfer.
   assign read_go = gap_ok & ~data_bus_busy_i;

   ////////////////////////////////////////////////////////////////////////
   // Head transaction sequencing.

   // The response is registered here and shows one clock later, so a
   // snoop flag set at the end of the snoop clock yields the two-clock
   // snoop-to-response distance without a separate counter.
   always_comb begin
      next_state = state;
      next_code = brp_pkg::RESP_IDLE;
      next_oe = 1'b0;
      next_wda = write_data_accept_o;
      next_fast_ok = fast_ok;
      unique case (state)
         brp_pkg::ST_IDLE: begin
            if (own_head && head_write) begin
               if (age_ok) begin
                  next_wda = 1'b1;
                  next_fast_ok = low_ok;
                  next_state = brp_pkg::ST_REQ_WDA;
               end
            end else if (own_head && head_snooped) begin
               if (head_mod_hit) begin
                  if (gap_ok) begin
                     next_wda = 1'b1;
                     next_state = brp_pkg::ST_WB_WDA;
                  end
               end else if (head_defer) begin
                  if (gap_ok) begin
                     next_code = brp_pkg::RESP_RETRY;
                     next_oe = 1'b1;
                     next_state = brp_pkg::ST_RESP;
                  end
               end else if (read_go) begin
                  next_code = brp_pkg::RESP_NORMAL;
                  next_oe = 1'b1;
                  next_state = brp_pkg::ST_RESP;
               end
            end
         end
         brp_pkg::ST_REQ_WDA: begin
            // Held until taken with a free data bus.
            if (!data_bus_busy_i && fast_ok) begin
               next_wda = 1'b0;
               next_state = brp_pkg::ST_REQ_DONE;
            end else if (!data_bus_busy_i) begin
               next_state = brp_pkg::ST_REQ_TAKEN;
            end else begin
               next_fast_ok = 1'b0;
            end
         end
         brp_pkg::ST_REQ_TAKEN: begin
            next_wda = 1'b0;
            next_state = brp_pkg::ST_REQ_DONE;
         end
         brp_pkg::ST_REQ_DONE: begin
            // Accept is already low here, so a writeback accept raised
            // now leaves the required idle clock between the two.
            if (head_snooped && gap_ok) begin
               if (head_mod_hit) begin
                  next_wda = 1'b1;
                  next_state = brp_pkg::ST_WB_WDA;
               end else if (head_defer) begin
                  next_code = brp_pkg::RESP_RETRY;
                  next_oe = 1'b1;
                  next_state = brp_pkg::ST_RESP;
               end else begin
                  next_code = brp_pkg::RESP_NO_DATA;
                  next_oe = 1'b1;
                  next_state = brp_pkg::ST_RESP;
               end
            end
         end
         brp_pkg::ST_WB_WDA: begin
            // The snooper starts the line in the response clock.
            if (!data_bus_busy_i) begin
               next_code = brp_pkg::RESP_IWB;
               next_oe = 1'b1;
               next_wda = 1'b0;
               next_state = brp_pkg::ST_RESP;
            end
         end
         brp_pkg::ST_RESP: begin
            // Code and enable fall back to idle by default.
            next_state = brp_pkg::ST_IDLE;
         end
      endcase
   end

   // State, response lines and accept strobe.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= brp_pkg::ST_IDLE;
         response_code_o <= brp_pkg::RESP_IDLE;
         response_parity_o <= 1'b0;
         response_oe_o <= 1'b0;
         write_data_accept_o <= 1'b0;
         write_data_accept_oe_o <= 1'b0;
         fast_ok <= 1'b0;
      end else begin
         state <= next_state;
         response_code_o <= next_code;
         response_parity_o <= ^next_code;
         response_oe_o <= next_oe;
         write_data_accept_o <= next_wda;
         write_data_accept_oe_o <= next_wda;
         fast_ok <= next_fast_ok;
      end
   end

   // Saturating distance counters: since the last bus response and
   // since the accept strobe was last active.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         gap_cnt <= brp_pkg::GAP_RST;
         wda_low_cnt <= brp_pkg::WDA_LOW_RST;
      end else begin
         if (bus_resp) gap_cnt <= 2'h0;
         else if (gap_cnt != 2'h3) gap_cnt <= 2'(gap_cnt + 2'h1);
         if (write_data_accept_o) wda_low_cnt <= 2'h0;
         else if (wda_low_cnt != 2'h3)
            wda_low_cnt <= 2'(wda_low_cnt + 2'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the driven lines.

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence s_wb_taken;
      state == brp_pkg::ST_WB_WDA && write_data_accept_o &&
         !data_bus_busy_i;
   endsequence

   sequence s_iwb_driven;
      response_oe_o && response_code_o == brp_pkg::RESP_IWB &&
         !write_data_accept_o;
   endsequence

   sequence s_req_pulse;
      $rose(write_data_accept_o) && state == brp_pkg::ST_REQ_WDA
         ##1 !write_data_accept_o;
   endsequence

   AST_PARITY: assert property (
      response_oe_o |-> response_parity_o == ^response_code_o)
      else $error("response parity does not match response code");

   AST_ONE_CLOCK: assert property (
      response_oe_o |=> !response_oe_o &&
         response_code_o == brp_pkg::RESP_IDLE)
      else $error("response held longer than one clock");

   AST_IDLE_OFF: assert property (
      !response_oe_o |-> response_code_o == brp_pkg::RESP_IDLE)
      else $error("response code active while not driving");

   AST_OWN_HEAD: assert property (
      response_oe_o |-> head_valid && head_ours)
      else $error("response driven for a transaction not owned");

   AST_IWB_TIMING: assert property (
      s_wb_taken |=> s_iwb_driven)
      else $error("writeback response not one clock after accept");

   AST_SPACING: assert property (
      bus_resp |=> !response_oe_o [*2])
      else $error("responses closer than three clocks");

   AST_READ_FREE: assert property (
      $rose(response_oe_o) &&
         response_code_o == brp_pkg::RESP_NORMAL |->
         $past(!data_bus_busy_i))
      else $error("read response while data bus busy");

   AST_SNOOPED: assert property (
      $rose(response_oe_o) |-> $past(head_snooped))
      else $error("response before snoop results observed");

   AST_WDA_DATA: assert property (
      $rose(write_data_accept_o) |-> head_write || head_mod_hit)
      else $error("write accept for a transaction without data");

   AST_WDA_AGE: assert property (
      $rose(write_data_accept_o) && state == brp_pkg::ST_REQ_WDA |->
         head_age >= 8'(brp_pkg::REQ_TO_WDA_CLK))
      else $error("write accept too early after request");

   AST_FAST_DROP: assert property (
      s_req_pulse |-> $past(!data_bus_busy_i) &&
         $past(wda_low_cnt, 2) >= brp_pkg::WDA_LOW_MIN)
      else $error("one-clock write accept not allowed here");

   AST_REQ_DROP: assert property (
      state == brp_pkg::ST_REQ_WDA && !data_bus_busy_i |->
         ##[1:2] !write_data_accept_o)
      else $error("write accept not dropped after being taken");

   AST_NODATA: assert property (
      $rose(response_oe_o) &&
         response_code_o == brp_pkg::RESP_NO_DATA |->
         $past(state) == brp_pkg::ST_REQ_DONE && !write_data_accept_o)
      else $error("no-data response before write accept cycle");

endmodule

// ### tb/brp_bus_model.sv
// Far-side bus agents: data source, data bus busy and foreign responses.
module brp_bus_model (
   // Clock and reset.
   input logic clk_sys_i,
   input logic rst_i,
   // Bus activity as seen on the wires.
   input logic strobe_i,
   input logic hit_i,
   input logic snoop_i,
   input logic [2:0] our_code_i,
   input logic accept_i,
   // Wired bus lines.
   output logic [2:0] bus_code_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic fq[$];
   int sq[$];
   int cyc;
   int last;
   logic [1:0] bcnt;
   logic [2:0] fcode;
   logic taken;

   // The response lines are wired: our drive and any foreign one merge.
   assign bus_code_o = our_code_i | fcode;
   assign busy_o = bcnt != 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // One process models every other agent, so queue views stay in step.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         fq.delete();
         sq.delete();
         cyc = 0;
         last = -10;
         bcnt <= 2'h0;
         fcode <= 3'h0;
         taken <= 1'b0;
      end else begin
         cyc++;
         // Data starts the clock after a taken accept; length varies.
         if (accept_i && !busy_o && !taken) begin
            bcnt <= 2'(cyc % 3);
            taken <= 1'b1;
         end else begin
            taken <= 1'b0;
            if (bcnt != 2'h0)
               bcnt <= bcnt - 2'h1;
         end
         // Read data runs with the normal data response.
         if (our_code_i == brp_pkg::RESP_NORMAL)
            bcnt <= 2'(cyc % 3);
         if (strobe_i)
            fq.push_back(!hit_i);
         if (snoop_i)
            sq.push_back(cyc);
         // Any active response retires the head entry.
         if (bus_code_o != 3'h0 && fq.size() > 0) begin
            fq.pop_front();
            if (sq.size() > 0)
               sq.pop_front();
            last = cyc;
         end
         // A foreign head answers no data for one clock, spaced out.
         fcode <= 3'h0;
         if (fcode == 3'h0 && fq.size() > 0 && sq.size() > 0) begin
            if (fq[0] && cyc >= sq[0] + 2 && cyc >= last + 3)
               fcode <= brp_pkg::RESP_NO_DATA;
         end
      end
   end
endmodule

// ### tb/testbench.sv
// Self-checking bench of the bus response-phase agent.
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin \
 miscompares++; $display("Error %0t: got %h want %h", $time, a, b); \
 end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, rst_i, strobe, wflag, hit, snoop, mod_hit, defer;
   logic [2:0] bus_code, code, want_code;
   logic parity, oe, acc, acc_oe, busy;
   logic [3:0] pending;
   logic [2:0] exp_code[$];
   int exp_acc[$];
   int miscompares, n_tests, seed, cyc, last_resp, acc_cnt, n_foreign;
   int want_foreign, tcyc, want_acc;
   logic prev_acc, prev_oe, prev_busy;
   logic w[64], hm[64], df[64];

   brp_resp_agent dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .request_strobe_i(strobe), .write_request_flag_i(wflag),
      .addr_hit_i(hit), .snoop_valid_i(snoop), .modified_hit_i(mod_hit),
      .snoop_defer_i(defer), .data_bus_busy_i(busy),
      .response_code_i(bus_code), .response_code_o(code),
      .response_parity_o(parity), .response_oe_o(oe),
      .write_data_accept_o(acc), .write_data_accept_oe_o(acc_oe),
      .pending_count_o(pending));

   brp_bus_model bus_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .strobe_i(strobe), .hit_i(hit), .snoop_i(snoop), .our_code_i(code),
      .accept_i(acc), .bus_code_o(bus_code), .busy_o(busy));

   // Free-running bus clock at 250 MHz.
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Pipelined requests, gap clocks apart, snoop results four clocks on.
   task automatic run_batch(input int n, input int gap, input bit rnd);
      int c, k;
      logic [31:0] r;
      for (c = 0; c <= gap * (n - 1) + 5; c++) begin
         @(negedge clk_sys_i);
         k = c / gap;
         strobe = (c % gap == 0) && k < n;
         if (strobe) begin
            r = $random(seed);
            hit = !(rnd && r[3] && r[4] && r[5]);
            w[k] = rnd && r[0] && hit;
            hm[k] = rnd && r[1] && r[2] && hit;
            df[k] = rnd && r[6] && !hm[k] && hit;
            wflag = w[k];
            if (!hit)
               want_foreign++;
            else begin
               exp_code.push_back(df[k] ? brp_pkg::RESP_RETRY :
                  hm[k] ? brp_pkg::RESP_IWB :
                  w[k] ? brp_pkg::RESP_NO_DATA : brp_pkg::RESP_NORMAL);
               exp_acc.push_back(int'(w[k]) + int'(hm[k]));
            end
         end
         k = (c - 4) / gap;
         snoop = c >= 4 && (c - 4) % gap == 0 && k < n;
         mod_hit = snoop && hm[k];
         defer = snoop && df[k];
      end
      for (c = 0; c < 600 && pending !== 4'h0; c++)
         @(negedge clk_sys_i);
      `CHECK(pending, 4'h0)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watcher: each driven response takes the oldest note off the queue.
   always @(posedge clk_sys_i) begin
      if (!rst_i) begin
         cyc++;
         if (acc && !prev_acc)
            acc_cnt++;
         `CHECK(acc_oe, acc)
         if (prev_oe)
            `CHECK(code, 3'h0)
         if (bus_code != 3'h0 && !oe)
            n_foreign++;
         if (oe) begin
            `CHECK(cyc - last_resp >= 3, 1'b1)
            `CHECK(parity, ^code)
            if (exp_code.size() == 0)
               `CHECK(oe, 1'b0)
            else begin
               // Notes come off first: the macro reads its arguments twice.
               want_code = exp_code.pop_front();
               want_acc = exp_acc.pop_front();
               `CHECK(code, want_code)
               `CHECK(acc_cnt, want_acc)
            end
            if (code == brp_pkg::RESP_NORMAL)
               `CHECK(prev_busy, 1'b0)
            acc_cnt = 0;
         end
         if (bus_code != 3'h0)
            last_resp = cyc;
         prev_acc = acc;
         prev_oe = oe;
         prev_busy = busy;
      end
   end

   // Cuts a hang short.
   always @(posedge clk_sys_i) begin
      tcyc++;
      if (tcyc > 5000) begin
         miscompares++;
         finish_test();
      end
   end

   // Main sequence: reset, back-to-back reads, then a random mix.
   initial begin
      seed = 32'h1109_1718;
      {strobe, wflag, hit, snoop, mod_hit, defer} = 6'h00;
      rst_i = 1'b1;
      last_resp = -10;
      repeat (8) @(negedge clk_sys_i);
      `CHECK({code, oe, acc, pending}, 9'h000)
      rst_i = 1'b0;
      run_batch(6, 3, 1'b0);
      run_batch(48, 8, 1'b1);
      `CHECK(exp_code.size(), 0)
      `CHECK(n_foreign, want_foreign)
      @(negedge clk_sys_i);
      rst_i = 1'b1;
      @(negedge clk_sys_i);
      `CHECK({code, acc, pending}, 8'h00)
      finish_test();
   end
endmodule
